// *** core/vssm_field_meas.sv ***
// Line and field measurement with per-field flag snapshot
`timescale 1ns/1ps
`default_nettype none
module vssm_field_meas #(
  parameter int CNT_W = 12,
  parameter int LN_W = 10,
  parameter logic [7:0] SHIFT_THRESH = vssm_pkg::SHIFT_THRESH_DEF,
  parameter logic [7:0] NOISE_LOW = vssm_pkg::NOISE_LOW_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsync_pulse,
  input wire logic vsync_pulse,
  input wire logic active_line,
  input wire logic vbi_active,
  input wire logic fast_blank_input,
  input wire logic field_rate_flag,
  input wire logic [7:0] blank_delta,
  input wire logic [7:0] noise_measure,
  input wire logic disc_in,
  input wire logic tape_in,
  vssm_if.meas m
);
  import vssm_pkg::*;
  logic [CNT_W-1:0] pix_cnt_q;
  logic [CNT_W-1:0] line_len_q;
  logic [LN_W-1:0] line_cnt_q;
  logic fb_prev_q, parity_q, fb_acc_q, ins_acc_q, shift_acc_q;
  logic [CNT_W+3:0] pos_x, len_x;
  logic near, parity_now, lines_ok, fb_edge, shift_ev;

  // Vsync position against the last line length, in tenths
  assign pos_x = (CNT_W+4)'(pix_cnt_q) * (CNT_W+4)'(PCT_DIV);
  assign len_x = (CNT_W+4)'(line_len_q);
  assign near = (pos_x >= len_x * NEAR_A_LO && pos_x <= len_x * NEAR_A_HI) ||
    (pos_x >= len_x * NEAR_B_LO && pos_x <= len_x * NEAR_B_HI);
  // Parity decision at the quarter and three-quarter points
  assign parity_now = (pix_cnt_q >= (line_len_q >> 2)) && (pix_cnt_q < line_len_q - (line_len_q >> 2));
  // Standard window chosen by the field rate
  assign lines_ok = field_rate_flag ? (line_cnt_q >= LINES_50_MIN && line_cnt_q <= LINES_50_MAX)
    : (line_cnt_q >= LINES_60_MIN && line_cnt_q <= LINES_60_MAX);
  assign fb_edge = (fast_blank_input != fb_prev_q) && active_line;
  // Shift counts only on a quiet picture, noise would fake it
  assign shift_ev = vbi_active && (blank_delta > SHIFT_THRESH) && (noise_measure < NOISE_LOW);

  // Sample and line counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_cnt_q <= '0;
      line_len_q <= '0;
      line_cnt_q <= '0;
      fb_prev_q <= 1'b0;
    end else begin
      fb_prev_q <= fast_blank_input;
      if (hsync_pulse) begin
        pix_cnt_q <= '0;
        line_len_q <= pix_cnt_q + CNT_W'(1);
      end else if (!(&pix_cnt_q)) begin
        pix_cnt_q <= pix_cnt_q + CNT_W'(1);
      end
      if (vsync_pulse) begin
        line_cnt_q <= '0;
      end else if (hsync_pulse && !(&line_cnt_q)) begin
        line_cnt_q <= line_cnt_q + LN_W'(1);
      end
    end
  end

  // Events seen during the running field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_acc_q <= 1'b0;
      ins_acc_q <= 1'b0;
      shift_acc_q <= 1'b0;
    end else begin
      fb_acc_q <= !vsync_pulse && (fb_acc_q || fast_blank_input);
      ins_acc_q <= !vsync_pulse && (ins_acc_q || fb_edge);
      shift_acc_q <= !vsync_pulse && (shift_acc_q || shift_ev);
    end
  end

  // Snapshot at each field boundary, held for the whole next field; field_done pulses one clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      parity_q <= 1'b0;
      m.vsync_near <= 1'b0;
      m.blank_shift <= 1'b0;
      m.interlaced <= 1'b0;
      m.disc <= 1'b0;
      m.tape <= 1'b0;
      m.insertion <= 1'b0;
      m.fast_blank <= 1'b0;
      m.trick <= 1'b0;
      m.field_done <= 1'b0;
    end else begin
      m.field_done <= vsync_pulse;
      if (vsync_pulse) begin
        parity_q <= parity_now;
        m.vsync_near <= near;
        m.interlaced <= parity_now != parity_q;
        m.disc <= disc_in;
        m.tape <= tape_in;
        m.trick <= !lines_ok;
        m.fast_blank <= fb_acc_q || fast_blank_input;
        m.insertion <= ins_acc_q || fb_edge;
        m.blank_shift <= shift_acc_q || shift_ev;
      end
    end
  end

  trick_50_a: assert property (@(posedge clk) disable iff (!rst_n)
    (vsync_pulse && field_rate_flag && line_cnt_q >= 10'd310 && line_cnt_q <= 10'd314) |=> !m.trick)
    else $error("trick flag set on standard 50 Hz field");
  trick_60_a: assert property (@(posedge clk) disable iff (!rst_n)
    (vsync_pulse && !field_rate_flag && (line_cnt_q < 10'd260 || line_cnt_q > 10'd264)) |=> m.trick)
    else $error("trick flag missing on odd 60 Hz field");
  fb_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (vsync_pulse && (fb_acc_q || fast_blank_input)) |=> (m.fast_blank throughout (!vsync_pulse [*1])))
    else $error("fast blank flag not held");
endmodule
`default_nettype wire

// *** core/vssm_if.sv ***
// Per-field status snapshot carried from the measurer to its readers
`timescale 1ns/1ps
`default_nettype none
interface vssm_if;
  logic vsync_near;
  logic blank_shift;
  logic interlaced;
  logic disc;
  logic tape;
  logic insertion;
  logic fast_blank;
  logic trick;
  logic field_done;
  modport meas(output vsync_near, blank_shift, interlaced, disc, tape, insertion, fast_blank, trick,
    field_done);
  modport mon(input vsync_near, blank_shift, interlaced, disc, tape, insertion, fast_blank, trick,
    field_done);
endinterface
`default_nettype wire

// *** core/vssm_irq_ack.sv ***
// Change-pending bits and self-clearing acknowledge registers
`timescale 1ns/1ps
`default_nettype none
module vssm_irq_ack (
  input wire logic clk,
  input wire logic rst_n,
  vssm_if.mon m,
  input wire logic ack_wr,
  input wire logic [7:0] ack_addr,
  input wire logic [7:0] ack_wdata,
  output logic irq
);
  import vssm_pkg::*;
  logic [15:0] cur, prev_q, pend_q, ack_q;

  // Monitored flags laid out as ack B above ack A
  always_comb begin
    cur = '0;
    cur[ACK_INTERLACE_BIT] = m.interlaced;
    cur[ACK_TAPE_BIT] = m.tape;
    cur[ACK_INSERT_BIT] = m.insertion;
    cur[ACK_FAST_BLANK_BIT] = m.fast_blank;
    cur[8 + ACK_NEAR_BIT] = m.vsync_near;
    cur[8 + ACK_TRICK_BIT] = m.trick;
  end

  // Ack bits live one clock, then fall by themselves
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= '0;
    end else begin
      ack_q <= '0;
      if (ack_wr && ack_addr == ADDR_ACK_A) begin
        ack_q[7:0] <= ack_wdata;
      end
      if (ack_wr && ack_addr == ADDR_ACK_B) begin
        ack_q[15:8] <= ack_wdata;
      end
    end
  end

  // A change in the same cycle as its ack stays pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0;
      pend_q <= '0;
    end else begin
      prev_q <= cur;
      pend_q <= (pend_q & ~ack_q) | (cur ^ prev_q);
    end
  end

  assign irq = |pend_q;

  ack_self_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ack_q != 16'h0000 && !ack_wr) |=> ack_q == 16'h0000)
    else $error("ack bit not cleared after one clock");
  change_pend_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cur != prev_q) |=> (irq && ((pend_q & $past(cur ^ prev_q)) == $past(cur ^ prev_q))))
    else $error("flag change did not raise pending");
endmodule
`default_nettype wire

// *** core/vssm_pkg.sv ***
// Shared constants for the video sync status monitor
`default_nettype none
package vssm_pkg;
  // Register byte addresses on the control port
  localparam logic [7:0] ADDR_SYNC_FLAGS = 8'h82;
  localparam logic [7:0] ADDR_NOISE = 8'h83;
  localparam logic [7:0] ADDR_SLICER_ID = 8'h84;
  localparam logic [7:0] ADDR_SLICER_RSV = 8'h85;
  localparam logic [7:0] ADDR_ANC = 8'h86;
  localparam logic [7:0] ADDR_ACK_A = 8'h7E;
  localparam logic [7:0] ADDR_ACK_B = 8'h7F;
  // Value of every status register after reset
  localparam logic [7:0] STATUS_RST = 8'h00;
  // Bit positions in the ancillary and PLL register
  localparam int ANC_PLL_BIT = 0;
  localparam int ANC_FIRST_BIT = 1;
  localparam int ANC_KINDS = 5;
  // Ack register A bit positions of the monitored flags
  localparam int ACK_INTERLACE_BIT = 7;
  localparam int ACK_TAPE_BIT = 6;
  localparam int ACK_INSERT_BIT = 5;
  localparam int ACK_FAST_BLANK_BIT = 4;
  // Ack register B bit positions
  localparam int ACK_NEAR_BIT = 1;
  localparam int ACK_TRICK_BIT = 0;
  // Vsync position bands in tenths of a line
  localparam logic [3:0] PCT_DIV = 4'hA;
  localparam logic [3:0] NEAR_A_LO = 4'h2;
  localparam logic [3:0] NEAR_A_HI = 4'h3;
  localparam logic [3:0] NEAR_B_LO = 4'h7;
  localparam logic [3:0] NEAR_B_HI = 4'h8;
  // Standard line counts per field
  localparam logic [9:0] LINES_50_MIN = 10'h136;
  localparam logic [9:0] LINES_50_MAX = 10'h13A;
  localparam logic [9:0] LINES_60_MIN = 10'h104;
  localparam logic [9:0] LINES_60_MAX = 10'h108;
  // Blank shift detection defaults
  localparam logic [7:0] SHIFT_THRESH_DEF = 8'h10;
  localparam logic [7:0] NOISE_LOW_DEF = 8'h20;
endpackage
`default_nettype wire

// *** core/vssm_top.sv ***
// Video sync status monitor: read-only status bank with field snapshots
//
// How it works
// - Field parity taken from Vsync position against quarter and three-quarter line.
// - Near-threshold flag when Vsync sits at 20-30 or 70-80 percent.
// - Blank shift flag on VBI blank move above threshold with low noise.
// - Interlace flag high for interlaced input, re-evaluated each field.
// - Separate flags for disc player source and tape source.
// - Insertion flag on any fast blank edge inside active line, held next field.
// - Fast blank present flag when input seen high in field, held next field.
// - At 50 Hz, 310 to 314 lines standard, else trick flag.
// - At 60 Hz, 260 to 264 lines standard, else trick flag.
// - Continuously computed 8-bit noise level readable.
// - 6-bit slicer identifier copy, two extra protection bits.
// - Five ancillary data kinds in bits 5..1, bits 7..6 reserved.
// - Bit 0 shows output PLL phase jumps active.
// - Registers 82h to 86h read-only, writes ignored.
// - Field rate flag, one for 50 Hz, picks line window.
// - Any monitored flag change raises pending interrupt until acknowledged.
// - Acknowledge bits clear themselves one clock after being written.
`timescale 1ns/1ps
`default_nettype none
module vssm_top #(
  parameter int CNT_W = 12,
  parameter int LN_W = 10,
  parameter logic [7:0] SHIFT_THRESH = vssm_pkg::SHIFT_THRESH_DEF,
  parameter logic [7:0] NOISE_LOW = vssm_pkg::NOISE_LOW_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsync_pulse,
  input wire logic vsync_pulse,
  input wire logic active_line,
  input wire logic vbi_active,
  input wire logic fast_blank_input,
  input wire logic field_rate_flag,
  input wire logic [7:0] blank_delta,
  input wire logic [7:0] noise_measure,
  input wire logic disc_source_in,
  input wire logic tape_source_in,
  input wire logic [5:0] slicer_identifier,
  input wire logic guide_data_pulse,
  input wire logic caption_data_pulse,
  input wire logic programme_system_pulse,
  input wire logic teletext_pulse,
  input wire logic widescreen_signal_pulse,
  input wire logic phase_jump_active,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic irq
);
  import vssm_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [7:0] noise_q;
  logic [7:0] slicer_q;
  logic [7:0] anc_q;
  logic [ANC_KINDS-1:0] anc_ev;
  logic [ANC_KINDS-1:0] anc_acc_q;
  logic [7:0] sync_flags;
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;
  logic rvalid_q;

  vssm_if fl();

  // Reset goes in at once, comes out after two clean edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Line, field and fast blank measurement
  vssm_field_meas #(
    .CNT_W(CNT_W),
    .LN_W(LN_W),
    .SHIFT_THRESH(SHIFT_THRESH),
    .NOISE_LOW(NOISE_LOW)
  ) u_meas (
    .clk(clk),
    .rst_n(rst_n),
    .hsync_pulse(hsync_pulse),
    .vsync_pulse(vsync_pulse),
    .active_line(active_line),
    .vbi_active(vbi_active),
    .fast_blank_input(fast_blank_input),
    .field_rate_flag(field_rate_flag),
    .blank_delta(blank_delta),
    .noise_measure(noise_measure),
    .disc_in(disc_source_in),
    .tape_in(tape_source_in),
    .m(fl.meas)
  );

  // Change detection and acknowledge registers
  vssm_irq_ack u_irq (
    .clk(clk),
    .rst_n(rst_n),
    .m(fl.mon),
    .ack_wr(reg_wr),
    .ack_addr(reg_addr),
    .ack_wdata(reg_wdata),
    .irq(irq)
  );

  // Noise follows the measurement every clock, no field latching
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      noise_q <= STATUS_RST;
    end else begin
      noise_q <= noise_measure;
    end
  end

  // Slicer id copy: bit 6 parity of even bits, bit 7 of odd bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slicer_q <= STATUS_RST;
    end else begin
      slicer_q[5:0] <= slicer_identifier;
      slicer_q[6] <= slicer_identifier[0] ^ slicer_identifier[2] ^ slicer_identifier[4];
      slicer_q[7] <= slicer_identifier[1] ^ slicer_identifier[3] ^ slicer_identifier[5];
    end
  end

  // Ancillary detections, highest bit first
  assign anc_ev = {guide_data_pulse, caption_data_pulse, programme_system_pulse, teletext_pulse,
    widescreen_signal_pulse};

  // Per-kind sticky catch over the field, snapshot at its end
  for (genvar i = 0; i < ANC_KINDS; i++) begin : g_anc
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        anc_acc_q[i] <= 1'b0;
        anc_q[ANC_FIRST_BIT + i] <= 1'b0;
      end else begin
        // Pulse in the boundary cycle belongs to the closing field
        anc_acc_q[i] <= !fl.field_done && (anc_acc_q[i] || anc_ev[i]);
        if (fl.field_done) begin
          anc_q[ANC_FIRST_BIT + i] <= anc_acc_q[i] || anc_ev[i];
        end
      end
    end
  end

  // Phase jump state is live, the PLL can switch mid-field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      anc_q[ANC_PLL_BIT] <= 1'b0;
      anc_q[7:6] <= 2'b00;
    end else begin
      anc_q[ANC_PLL_BIT] <= phase_jump_active;
      anc_q[7:6] <= 2'b00;
    end
  end

  // Condition flags, vsync-near in bit 7 down to trick in bit 0
  assign sync_flags = {fl.vsync_near, fl.blank_shift, fl.interlaced, fl.disc, fl.tape, fl.insertion,
    fl.fast_blank, fl.trick};

  // Read decode; ack and unmapped addresses read as zero
  always_comb begin
    unique case (reg_addr)
      ADDR_SYNC_FLAGS: rd_mux = sync_flags;
      ADDR_NOISE: rd_mux = noise_q;
      ADDR_SLICER_ID: rd_mux = slicer_q;
      ADDR_SLICER_RSV: rd_mux = STATUS_RST;
      ADDR_ANC: rd_mux = anc_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data one clock after the strobe; writes never touch these
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  noise_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> noise_q == $past(noise_measure))
    else $error("noise level not tracking measurement");

  slicer_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> (slicer_q[5:0] == $past(slicer_identifier) &&
    slicer_q[6] == ^($past(slicer_identifier) & 6'h15) &&
    slicer_q[7] == ^($past(slicer_identifier) & 6'h2A)))
    else $error("slicer id copy or protection wrong");

  anc_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fl.field_done && guide_data_pulse) |=> anc_q[5])
    else $error("guide data not captured at field end");

  anc_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    anc_q[7:6] == 2'b00)
    else $error("reserved ancillary bits not zero");

  anc_snapshot_a: assert property (@(posedge clk) disable iff (!rst_n)
    !fl.field_done |=> $stable(anc_q[5:1]))
    else $error("ancillary flags moved inside a field");

  anc_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    fl.field_done |=> (anc_q[5:1] & ~$past(anc_acc_q | anc_ev)) == 5'h00)
    else $error("quiet field left ancillary flags set");

  pll_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(phase_jump_active) |=> anc_q[0])
    else $error("phase jump bit missed rise");

  ro_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr >= 8'h82 && reg_addr <= 8'h86 && !vsync_pulse) |=> $stable(sync_flags))
    else $error("write changed read-only flags");

  read_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == 8'h86) |=> (reg_rvalid && reg_rdata == $past(anc_q)))
    else $error("read of 86h gave wrong answer");

  read_ack_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && (reg_addr == 8'h7E || reg_addr == 8'h7F)) |=> reg_rdata == 8'h00)
    else $error("ack register readable");

  rvalid_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> !reg_rvalid)
    else $error("read valid without strobe");
endmodule
`default_nettype wire

// *** sim/test_video_sync_status_monitor.sv ***
// Self-checking bench for the video sync status monitor
`timescale 1ns/1ps
`default_nettype none
module test_video_sync_status_monitor;
  import vssm_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] e;
    logic [7:0] m;
  } vssm_exp_t;
  localparam int LEN = 20;
  logic clk, resetn, field_rate_flag, disc_source_in, tape_source_in, phase_jump_active;
  logic guide_data_pulse, caption_data_pulse, programme_system_pulse, teletext_pulse, widescreen_signal_pulse;
  logic hsync_pulse, vsync_pulse, active_line, vbi_active, fast_blank_input;
  logic [7:0] blank_delta, noise_measure, reg_addr, reg_wdata, reg_rdata, prev_e;
  logic [5:0] slicer_identifier;
  logic reg_wr, reg_rd, reg_rvalid, irq;
  vssm_exp_t q[$];
  vssm_exp_t x;
  int error_cnt, num_checks, seed, prev_k;
  // Field table: line count, vsync offset, fast blank pattern
  int ln[9] = '{309, 310, 314, 315, 259, 260, 264, 265, 312};
  int kt[9] = '{10, 10, 2, 2, 10, 2, 2, 10, 15};
  int fbt[9] = '{0, 1, 2, 0, 2, 1, 0, 2, 0};

  vssm_top DUT (.clk(clk), .resetn(resetn), .hsync_pulse(hsync_pulse), .vsync_pulse(vsync_pulse),
    .active_line(active_line), .vbi_active(vbi_active), .fast_blank_input(fast_blank_input),
    .field_rate_flag(field_rate_flag), .blank_delta(blank_delta), .noise_measure(noise_measure),
    .disc_source_in(disc_source_in), .tape_source_in(tape_source_in), .slicer_identifier(slicer_identifier),
    .guide_data_pulse(guide_data_pulse), .caption_data_pulse(caption_data_pulse),
    .programme_system_pulse(programme_system_pulse), .teletext_pulse(teletext_pulse),
    .widescreen_signal_pulse(widescreen_signal_pulse), .phase_jump_active(phase_jump_active),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq(irq));

  vssm_src_model #(.LEN(LEN)) src (.clk(clk), .hsync_pulse(hsync_pulse), .vsync_pulse(vsync_pulse),
    .active_line(active_line), .vbi_active(vbi_active), .fast_blank_input(fast_blank_input));

  always #2 clk = ~clk;

  task automatic cmp_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] reg %h expected %h got %h", a, e, g);
    end
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b got %b", n, e, g);
    end
  endtask

  // Reads and writes hold their strobe until the next call or idle
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_addr = a;
    q.push_back('{a: a, e: e & m, m: m});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
  endtask

  task automatic idle();
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
  endtask

  // Odd field when Vsync sits in the middle half of the line
  function automatic logic odd(input int k);
    return (k >= LEN / 4) && (k < LEN - LEN / 4);
  endfunction

  // Read answers are matched oldest first
  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (q.size() == 0) begin
        error_cnt++;
        $display("[ERR] rvalid expected 0 got 1");
      end else begin
        x = q.pop_front();
        cmp_reg(x.a, x.e, reg_rdata & x.m);
      end
    end
  end

  // One field, then snapshot checks, interrupt, acknowledge
  task automatic field(input int n, input logic rate, input int k, input int fb, input int sel, input int chk);
    logic [7:0] e;
    logic [7:0] m;
    logic [4:0] anc;
    logic pj;
    // Drops a read strobe left standing by the caller
    idle();
    anc = 5'($random(seed));
    pj = 1'($random(seed));
    field_rate_flag = rate;
    blank_delta = (sel == 0) ? SHIFT_THRESH_DEF + 8'h01 : (sel == 1) ? SHIFT_THRESH_DEF : 8'hFF;
    noise_measure = (sel == 0) ? NOISE_LOW_DEF - 8'h01 : (sel == 1) ? 8'h00 : NOISE_LOW_DEF;
    disc_source_in = n[0];
    tape_source_in = n[1];
    phase_jump_active = pj;
    {guide_data_pulse, caption_data_pulse, programme_system_pulse, teletext_pulse, widescreen_signal_pulse} = anc;
    @(posedge clk);
    #1;
    {guide_data_pulse, caption_data_pulse, programme_system_pulse, teletext_pulse, widescreen_signal_pulse} = 5'h00;
    src.run(n, k, fb);
    // Parity at the three-quarter point (offset 15) is uncertain, so interlace is masked there
    m = (k == 15) ? 8'hDF : 8'hFF;
    e[7] = (k == 15);
    e[6] = (blank_delta > SHIFT_THRESH_DEF) && (noise_measure < NOISE_LOW_DEF);
    e[5] = odd(k) != odd(prev_k);
    e[4] = n[0];
    e[3] = n[1];
    e[2] = (fb == 2);
    e[1] = (fb != 0);
    e[0] = rate ? (n < 310 || n > 314) : (n < 260 || n > 264);
    if (chk > 0) begin
      rd(ADDR_SYNC_FLAGS, e, m);
      rd(ADDR_ANC, {2'b00, anc, pj}, 8'hFF);
    end
    if (chk > 1) begin
      cmp_bit("irq", |((e ^ prev_e) & 8'hAF & m), irq);
    end
    wr(ADDR_ACK_A, 8'hFF);
    wr(ADDR_ACK_B, 8'hFF);
    idle();
    repeat (3) @(posedge clk);
    #1;
    if (chk > 1) begin
      cmp_bit("irq", 1'b0, irq);
    end
    prev_e = e;
    prev_k = k;
  endtask

  task automatic end_of_test();
    if (q.size() != 0) begin
      error_cnt++;
      $display("[ERR] pending reads expected 0 got %0d", q.size());
    end
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog well past the expected run of about 65k cycles
  initial begin
    #400000;
    error_cnt++;
    $display("[ERR] watchdog expected done got timeout");
    end_of_test();
  end

  initial begin
    seed = 32'hB2CF;
    {clk, resetn, field_rate_flag, disc_source_in, tape_source_in, phase_jump_active} = 6'h00;
    {guide_data_pulse, caption_data_pulse, programme_system_pulse, teletext_pulse, widescreen_signal_pulse} = 5'h00;
    {blank_delta, noise_measure, reg_addr, reg_wdata} = 32'h0;
    {slicer_identifier, reg_wr, reg_rd} = 8'h00;
    error_cnt = 0;
    num_checks = 0;
    prev_k = 2;
    prev_e = 8'h00;
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge clk);
    // Cleared bank after reset, the designer's chosen value
    for (int a = 8'h82; a <= 8'h86; a++) rd(8'(a), STATUS_RST, 8'hFF);
    // Two settling fields, then the table covering both rates and both edges of each window
    field(312, 1'b1, 2, 0, 1, 0);
    field(312, 1'b1, 2, 0, 1, 1);
    for (int i = 0; i < 9; i++) field(ln[i], (i < 4) || (i == 8), kt[i], fbt[i], i % 3, 2);
    // Slicer copy and noise readback, with writes aimed at the read-only bank
    for (int i = 0; i < 4; i++) begin
      logic [5:0] s;
      // Last read of the previous pass must not repeat
      idle();
      s = 6'($random(seed));
      slicer_identifier = s;
      noise_measure = 8'($random(seed));
      repeat (2) @(posedge clk);
      for (int a = 8'h82; a <= 8'h86; a++) wr(8'(a), 8'($random(seed)));
      rd(ADDR_NOISE, noise_measure, 8'hFF);
      rd(ADDR_SLICER_ID, {s[1] ^ s[3] ^ s[5], s[0] ^ s[2] ^ s[4], s}, 8'hFF);
      rd(ADDR_SYNC_FLAGS, prev_e, 8'hDF);
      rd(ADDR_SLICER_RSV, 8'h00, 8'hFF);
      rd(8'h90, 8'h00, 8'hFF);
      rd(ADDR_ACK_A, 8'h00, 8'hFF);
    end
    idle();
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire

// *** sim/vssm_src_model.sv ***
// Behavioural analog video source: line and field timing with fast blank
`timescale 1ns/1ps
`default_nettype none
module vssm_src_model #(
  parameter int LEN = 20
) (
  input wire logic clk,
  output var logic hsync_pulse,
  output var logic vsync_pulse,
  output var logic active_line,
  output var logic vbi_active,
  output var logic fast_blank_input
);
  // Between fields every timing line rests low
  initial begin
    hsync_pulse = 1'b0;
    vsync_pulse = 1'b0;
    active_line = 1'b0;
    vbi_active = 1'b0;
    fast_blank_input = 1'b0;
  end

  // One field of n lines; vsync lands at offset k of the last line
  // Fast blank: 1 = high in a blanking line, 2 = short pulse inside active video
  task automatic run(input int n, input int k, input int fb);
    for (int l = 0; l < n; l++) begin
      for (int c = 0; c < LEN; c++) begin
        @(posedge clk);
        #1;
        hsync_pulse = (c == 0);
        vsync_pulse = (l == n - 1) && (c == k);
        vbi_active = (l < 20);
        active_line = (l >= 20) && (c >= 4) && (c < 18);
        fast_blank_input = ((fb == 1) && (l == 1) && (c >= 4) && (c < 18)) ||
          ((fb == 2) && (l == 30) && (c >= 8) && (c < 10));
      end
    end
    @(posedge clk);
    #1;
    hsync_pulse = 1'b0;
    vsync_pulse = 1'b0;
    active_line = 1'b0;
    vbi_active = 1'b0;
    fast_blank_input = 1'b0;
  endtask
endmodule
`default_nettype wire
